// ---- hdl/uart_async_modes_baud_select.sv ----
// async serial port with mode framing and baud source selection
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// What this block does
// - 8-bit variable mode: start low, eight data LSB first, stop high
// - data register write starts transmit; 8-bit mode loads stop as ninth
// - transmit flag set as the stop bit begins on the line
// - receiver starts on a falling receive edge, needs a valid start
// - 8-bit receive: data to register, stop to ninth flag, set flag
// - frame kept only if receive flag clear and stop bit high
// - 9-bit fixed mode: start, eight data, ninth bit, stop
// - 9-bit transmit loads ninth bit; shifting starts on next tick
// - 9-bit receive: data to register, ninth to flag, set flag
// - 9-bit variable mode equals fixed mode with timer rate
// - async receive needs enable; shift mode needs enable and clear flag
// - shift mode bit rate is core clock over twelve
// - 9-bit fixed rate core over 32, or over 16 when doubled
// - variable rates from timer one, timer two, or one each way
// - timer one rate is overflow rate times doubling over 32
// - timer one autoreload gives core over 256 minus reload byte
// - timer two: sixteen overflows per bit, counts every two clocks
// - each clock-select bit moves only its own direction to timer two
// - timer two rate is core over thirty-two times 65536 minus reload
// - 9-bit modes with multiprocessor enable drop ninth-bit-zero frames
// - timer two overflow flag not set while used as rate source
module uart_async_modes_baud_select (
    // clock, reset, enable
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CE_IN,
    // register bus
    input wire uart_pkg::apb_req_s APB_REQ_IN,
    output uart_pkg::apb_rsp_s APB_RSP_OUT,
    // serial lines and the timer two external edge input
    input wire logic RX_IN,
    input wire logic EXT_EDGE_IN,
    output logic TX_OUT
);
    uart_pkg::state_s st_q;
    uart_pkg::state_s st_d;
    logic rst_meta_q;
    logic rst_n;
    logic [1:0] mode;
    logic nine, mode0, acc, wr, hit, tx_load;
    logic ovf1, ovf2, m0_tick, m2_tick, t1_tick;
    logic tx_tick, rx_tick, ti_set, ri_set, fall, accept;
    logic [3:0] last, mid, total;
    logic [31:0] rdval;

    function automatic logic [3:0] next_ph(input logic [3:0] ph,
                                           input logic [3:0] lim);
        next_ph = (ph == lim) ? 4'h0 : ph + 4'h1;
    endfunction : next_ph

    // variable modes pick timer two per direction, else timer one
    function automatic logic pick_tick(input logic [1:0] md,
                                       input logic use_t2,
                                       input logic t0, input logic t2f,
                                       input logic t1, input logic t2);
        case (md)
            uart_pkg::MODE_SHIFT: pick_tick = t0;
            uart_pkg::MODE_9FIX: pick_tick = t2f;
            default: pick_tick = use_t2 ? t2 : t1;
        endcase
    endfunction : pick_tick

    // reset released through two flops
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    always_comb begin
        st_d = st_q;
        rdval = 32'h0000_0000;
        hit = 1'b1;
        tx_load = 1'b0;
        ovf1 = 1'b0;
        ovf2 = 1'b0;
        ti_set = 1'b0;
        ri_set = 1'b0;
        accept = 1'b0;
        mode = {st_q.ctrl[uart_pkg::B_MODE_HI],
                st_q.ctrl[uart_pkg::B_MODE_LO]};
        nine = mode[1];
        mode0 = (mode == uart_pkg::MODE_SHIFT);
        // synchronisers; the second stage is sampled, the third is used only to find edges
        st_d.rx_m = RX_IN;
        st_d.rx_s = st_q.rx_m;
        st_d.rx_p = st_q.rx_s;
        st_d.ext_m = EXT_EDGE_IN;
        st_d.ext_s = st_q.ext_m;
        st_d.ext_p = st_q.ext_s;
        fall = st_q.rx_p & ~st_q.rx_s;

        // apb: access phase answered one cycle later
        acc = APB_REQ_IN.psel & APB_REQ_IN.penable & ~st_q.pready;
        wr = acc & APB_REQ_IN.pwrite;
        case (APB_REQ_IN.paddr)
            uart_pkg::OFF_CTRL: begin
                rdval = {24'h0, st_q.ctrl};
                if (wr) begin
                    st_d.ctrl = APB_REQ_IN.pwdata[7:0];
                end
            end
            uart_pkg::OFF_DATA: begin
                rdval = {24'h0, st_q.rxd};
                tx_load = wr;
            end
            uart_pkg::OFF_PWR: begin
                rdval = {24'h0, st_q.dbl, 7'h00};
                if (wr) begin
                    st_d.dbl = APB_REQ_IN.pwdata[uart_pkg::B_DOUBLE];
                end
            end
            uart_pkg::OFF_T2CTRL: begin
                rdval = {24'h0, st_q.tf2, st_q.timer_two_external_flag, st_q.rclk,
                         st_q.tx_rate_from_timer_two, 4'h0};
                if (wr) begin
                    st_d.tf2 = APB_REQ_IN.pwdata[uart_pkg::B_T2OVF];
                    st_d.timer_two_external_flag = APB_REQ_IN.pwdata[uart_pkg::B_T2EXT];
                    st_d.rclk = APB_REQ_IN.pwdata[uart_pkg::B_T2RX];
                    st_d.tx_rate_from_timer_two = APB_REQ_IN.pwdata[uart_pkg::B_T2TX];
                end
            end
            uart_pkg::OFF_T2RLD: begin
                rdval = {16'h0, st_q.t2rld};
                if (wr) begin
                    st_d.t2rld = APB_REQ_IN.pwdata[15:0];
                end
            end
            uart_pkg::OFF_TMODE: begin
                rdval = {24'h0, st_q.tmode};
                if (wr) begin
                    st_d.tmode = APB_REQ_IN.pwdata[7:0];
                end
            end
            uart_pkg::OFF_T1RLD: begin
                rdval = {24'h0, st_q.t1rld};
                if (wr) begin
                    st_d.t1rld = APB_REQ_IN.pwdata[7:0];
                end
            end
            default: begin
                hit = 1'b0;
                tx_load = 1'b0;
            end
        endcase
        st_d.pready = acc;
        if (acc) begin
            st_d.pslverr = ~hit;
            st_d.prdata = APB_REQ_IN.pwrite ? 32'h0000_0000 : rdval;
        end else begin
            st_d.pslverr = 1'b0;
        end

        // timer one, 8-bit autoreload only
        if (st_q.tmode[7:4] == uart_pkg::T1_AUTORELOAD) begin
            if (st_q.t1cnt == 8'hFF) begin
                st_d.t1cnt = st_q.t1rld;
                ovf1 = 1'b1;
            end else begin
                st_d.t1cnt = st_q.t1cnt + 8'h01;
            end
        end
        if (ovf1) begin
            st_d.t1half = ~st_q.t1half;
        end
        t1_tick = ovf1 & (st_q.dbl | st_q.t1half);

        // timer two runs as rate source, counting every second clock
        if (st_q.tx_rate_from_timer_two | st_q.rclk) begin
            st_d.t2pre = ~st_q.t2pre;
            if (st_q.t2pre) begin
                if (st_q.t2cnt == 16'hFFFF) begin
                    st_d.t2cnt = st_q.t2rld;
                    ovf2 = 1'b1;
                end else begin
                    st_d.t2cnt = st_q.t2cnt + 16'h0001;
                end
            end
        end

        // a reload write loads the count too, so a new rate starts at once
        if (wr && APB_REQ_IN.paddr == uart_pkg::OFF_T2RLD) begin
            st_d.t2cnt = APB_REQ_IN.pwdata[15:0];
        end
        // fixed dividers: ticks are 16 per bit in async modes
        st_d.m2pre = ~st_q.m2pre;
        m2_tick = st_q.dbl | st_q.m2pre;
        m0_tick = (st_q.m0cnt == uart_pkg::M0_LAST);
        st_d.m0cnt = m0_tick ? 4'h0 : st_q.m0cnt + 4'h1;

        tx_tick = pick_tick(mode, st_q.tx_rate_from_timer_two, m0_tick, m2_tick,
                            t1_tick, ovf2);
        rx_tick = pick_tick(mode, st_q.rclk, m0_tick, m2_tick,
                            t1_tick, ovf2);
        // shift mode has one tick per bit, so it samples on every one
        last = mode0 ? 4'h0 : uart_pkg::PH_LAST;
        mid = mode0 ? 4'h0 : uart_pkg::PH_MID;
        total = mode0 ? uart_pkg::BITS_M0 :
                (nine ? uart_pkg::BITS_M9 : uart_pkg::BITS_M8);

        // transmitter
        case (st_q.txst)
            uart_pkg::TX_IDLE: begin
                st_d.txline = 1'b1;
            end
            uart_pkg::TX_WAIT: begin
                if (tx_tick) begin
                    st_d.txph = 4'h0;
                    st_d.txst = uart_pkg::TX_SEND;
                    if (mode0) begin
                        st_d.txline = st_q.txsh[0];
                        st_d.txsh = {1'b1, st_q.txsh[9:1]};
                        st_d.txbits = 4'h1;
                    end else begin
                        st_d.txline = 1'b0;
                        st_d.txbits = 4'h0;
                    end
                end
            end
            uart_pkg::TX_SEND: begin
                if (tx_tick) begin
                    st_d.txph = next_ph(st_q.txph, last);
                    if (st_q.txph == last) begin
                        if (st_q.txbits == total) begin
                            st_d.txst = uart_pkg::TX_IDLE;
                            st_d.txline = 1'b1;
                            ti_set = mode0;
                        end else begin
                            st_d.txline = st_q.txsh[0];
                            st_d.txsh = {1'b1, st_q.txsh[9:1]};
                            st_d.txbits = st_q.txbits + 4'h1;
                            ti_set = ~mode0 &
                                (st_q.txbits + 4'h1 == total);
                        end
                    end
                end
            end
            default: begin
                st_d.txst = uart_pkg::TX_IDLE;
            end
        endcase
        // a write restarts the shifter even mid-frame
        if (tx_load) begin
            st_d.txsh = {1'b1,
                         nine ? st_q.ctrl[uart_pkg::B_TB8] : 1'b1,
                         APB_REQ_IN.pwdata[7:0]};
            st_d.txst = uart_pkg::TX_WAIT;
        end

        // receiver
        case (st_q.rxst)
            uart_pkg::RX_IDLE: begin
                st_d.rxph = 4'h0;
                st_d.rxbits = 4'h0;
                if (st_q.ctrl[uart_pkg::B_REN]) begin
                    if (mode0) begin
                        if (!st_q.ctrl[uart_pkg::B_RI]) begin
                            st_d.rxst = uart_pkg::RX_DATA;
                        end
                    end else if (fall) begin
                        st_d.rxst = uart_pkg::RX_START;
                    end
                end
            end
            uart_pkg::RX_START: begin
                if (rx_tick) begin
                    st_d.rxph = next_ph(st_q.rxph, last);
                    if (st_q.rxph == mid && st_q.rx_s) begin
                        st_d.rxst = uart_pkg::RX_IDLE;
                    end else if (st_q.rxph == last) begin
                        st_d.rxst = uart_pkg::RX_DATA;
                    end
                end
            end
            uart_pkg::RX_DATA: begin
                if (rx_tick) begin
                    st_d.rxph = next_ph(st_q.rxph, last);
                    if (st_q.rxph == mid) begin
                        st_d.rxsh[st_q.rxbits] = st_q.rx_s;
                        st_d.rxbits = st_q.rxbits + 4'h1;
                        if (st_q.rxbits + 4'h1 == total) begin
                            st_d.rxst = uart_pkg::RX_IDLE;
                            accept = ~st_q.ctrl[uart_pkg::B_RI] &
                                (mode0 |
                                 ((nine ? st_d.rxsh[9] : st_d.rxsh[8]) &
                                  (~(nine & st_q.ctrl[uart_pkg::B_MP]) |
                                   st_d.rxsh[8])));
                        end
                    end
                end
            end
            default: begin
                st_d.rxst = uart_pkg::RX_IDLE;
            end
        endcase
        if (accept) begin
            st_d.rxd = st_d.rxsh[7:0];
            ri_set = 1'b1;
            if (!mode0) begin
                st_d.ctrl[uart_pkg::B_RB8] = st_d.rxsh[8];
            end
        end

        // hardware sets win over a software clear in the same cycle
        if (ti_set) begin
            st_d.ctrl[uart_pkg::B_TI] = 1'b1;
        end
        if (ri_set) begin
            st_d.ctrl[uart_pkg::B_RI] = 1'b1;
        end
        if (st_q.ext_p & ~st_q.ext_s) begin
            st_d.timer_two_external_flag = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.rx_m <= 1'b1;
            st_q.rx_s <= 1'b1;
            st_q.rx_p <= 1'b1;
            st_q.ext_m <= 1'b1;
            st_q.ext_s <= 1'b1;
            st_q.ext_p <= 1'b1;
            st_q.ctrl <= uart_pkg::RST_BYTE;
            st_q.t2rld <= uart_pkg::RST_WORD;
            st_q.txst <= uart_pkg::TX_IDLE;
            st_q.rxst <= uart_pkg::RX_IDLE;
            st_q.txline <= 1'b1;
        end else if (CE_IN) begin
            st_q <= st_d;
        end
    end

    assign TX_OUT = st_q.txline;
    assign APB_RSP_OUT.pready = st_q.pready;
    assign APB_RSP_OUT.pslverr = st_q.pslverr;
    assign APB_RSP_OUT.prdata = st_q.prdata;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!rst_n);

    sequence s_mid_high;
        st_q.rxst == uart_pkg::RX_START && rx_tick &&
        st_q.rxph == mid && st_q.rx_s;
    endsequence
    sequence s_idle_then_start;
        st_q.rxst == uart_pkg::RX_IDLE ##1
        st_q.rxst == uart_pkg::RX_START;
    endsequence

    tx_idle_high_a: assert property (
        st_q.txst == uart_pkg::TX_IDLE |-> TX_OUT)
        else $error("tx line low while idle");
    tx_flag_stop_a: assert property (
        CE_IN && ti_set && !mode0 |=> TX_OUT && st_q.ctrl[uart_pkg::B_TI])
        else $error("tx flag not set with stop bit");
    data_write_a: assert property (
        CE_IN && tx_load |=> st_q.txst == uart_pkg::TX_WAIT)
        else $error("data write did not start transmit");
    rx_accept_a: assert property (
        ri_set |-> !st_q.ctrl[uart_pkg::B_RI])
        else $error("frame accepted while flag set");
    start_abort_a: assert property (
        (CE_IN and s_mid_high) |=> st_q.rxst == uart_pkg::RX_IDLE)
        else $error("false start not abandoned");
    rx_enable_a: assert property (
        s_idle_then_start |-> $past(st_q.ctrl[uart_pkg::B_REN]))
        else $error("receive began while disabled");
    rx_stop_ninth_a: assert property (
        CE_IN && ri_set && mode == uart_pkg::MODE_8VAR
        |=> st_q.ctrl[uart_pkg::B_RB8])
        else $error("stop bit not stored");
    mp_drop_a: assert property (
        ri_set && nine && st_q.ctrl[uart_pkg::B_MP] |-> st_d.rxsh[8])
        else $error("ninth zero frame accepted");
    fix_double_a: assert property (
        st_q.dbl && mode == uart_pkg::MODE_9FIX |-> tx_tick && rx_tick)
        else $error("doubled fixed rate missed a tick");
    t2_no_ovf_a: assert property (
        CE_IN && (st_q.tx_rate_from_timer_two | st_q.rclk) && !wr |=> !$rose(st_q.tf2))
        else $error("timer two overflow flag set");
    apb_ready_a: assert property (
        CE_IN && acc |=> APB_RSP_OUT.pready ##1 !APB_RSP_OUT.pready)
        else $error("apb answer not one cycle");
endmodule : uart_async_modes_baud_select

// ---- pkg/uart_pkg.sv ----
// constants, types and state layout of the async serial port
package uart_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_PWR = 8'h08;
    localparam logic [7:0] OFF_T2CTRL = 8'h0C;
    localparam logic [7:0] OFF_T2RLD = 8'h10;
    localparam logic [7:0] OFF_TMODE = 8'h14;
    localparam logic [7:0] OFF_T1RLD = 8'h18;
    // serial_control_reg fields
    localparam int B_MODE_HI = 7;
    localparam int B_MODE_LO = 6;
    localparam int B_MP = 5;
    localparam int B_REN = 4;
    localparam int B_TB8 = 3;
    localparam int B_RB8 = 2;
    localparam int B_TI = 1;
    localparam int B_RI = 0;
    // other fields
    localparam int B_DOUBLE = 7;
    localparam int B_T2OVF = 7;
    localparam int B_T2EXT = 6;
    localparam int B_T2RX = 5;
    localparam int B_T2TX = 4;
    localparam logic [3:0] T1_AUTORELOAD = 4'h2;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // modes
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8VAR = 2'h1;
    localparam logic [1:0] MODE_9FIX = 2'h2;
    localparam logic [1:0] MODE_9VAR = 2'h3;
    // timing counts
    localparam logic [3:0] PH_LAST = 4'hF;
    localparam logic [3:0] PH_MID = 4'h7;
    localparam logic [3:0] M0_LAST = 4'hB;
    localparam logic [3:0] BITS_M0 = 4'h8;
    localparam logic [3:0] BITS_M8 = 4'h9;
    localparam logic [3:0] BITS_M9 = 4'hA;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} tx_state_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic rx_m, rx_s, rx_p, ext_m, ext_s, ext_p;
        logic pready, pslverr;
        logic [31:0] prdata;
        logic [7:0] ctrl, rxd, tmode, t1rld;
        logic dbl, tf2, timer_two_external_flag, rclk, tx_rate_from_timer_two;
        logic [15:0] t2rld, t2cnt;
        logic [7:0] t1cnt;
        logic t1half, t2pre, m2pre;
        logic [3:0] m0cnt;
        tx_state_e txst;
        logic [9:0] txsh;
        logic [3:0] txph, txbits;
        logic txline;
        rx_state_e rxst;
        logic [9:0] rxsh;
        logic [3:0] rxph, rxbits;
    } state_s;
endpackage : uart_pkg

// ---- tb/uart_remote_node.sv ----
// remote serial node on the far end of the transmit and receive lines
`timescale 1ns/1ps
module uart_remote_node (
    // clock
    input wire logic clk_in,
    // serial lines
    input wire logic line_in,
    output logic line_out
);
    // the node drives the line high from time zero, so an idle line reads high
    initial line_out = 1'b1;
    // drives a frame lsb first, one bit every per cycles
    task automatic send(input int nb, input logic [10:0] bits,
        input int per);
        for (int i = 0; i < nb; i++) begin
            line_out <= bits[i];
            repeat (per) @(posedge clk_in);
        end
        line_out <= 1'b1;
    endtask : send
    // samples mid-bit; a start bit that never comes stops the wait after 5000 cycles, then it samples anyway
    task automatic grab(input int nb, input int per,
        output logic [10:0] bits);
        int n = 0;
        bits = 11'h000;
        while (line_in !== 1'b0 && n < 5000) begin
            @(posedge clk_in);
            n++;
        end
        repeat (per / 2) @(posedge clk_in);
        for (int i = 0; i < nb; i++) begin
            bits[i] = line_in;
            repeat (per) @(posedge clk_in);
        end
    endtask : grab
endmodule : uart_remote_node

// ---- tb/uart_async_modes_baud_select_tb_top.sv ----
// self-checking bench for the async serial port
`timescale 1ns/1ps
`define CHK(nm, e_, g_) begin check_count++; if ((g_) !== (e_)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e_, g_); end end
module uart_async_modes_baud_select_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic ext = 1'b1;
    logic rx_line;
    logic tx_line;
    logic [10:0] got;
    uart_pkg::apb_req_s req = '0;
    uart_pkg::apb_rsp_s rsp;
    int error_cnt = 0;
    int check_count = 0;

    always #12.5 clk = ~clk;

    uart_async_modes_baud_select uart_async_modes_baud_select_inst (
        .CORE_CLK_IN(clk),
        .RESETN_IN(rst_n),
        .CE_IN(ce),
        .APB_REQ_IN(req),
        .APB_RSP_OUT(rsp),
        .RX_IN(rx_line),
        .EXT_EDGE_IN(ext),
        .TX_OUT(tx_line)
    );

    uart_remote_node uart_remote_node_inst (
        .clk_in(clk),
        .line_in(tx_line),
        .line_out(rx_line)
    );

    // one transfer; entered just after a rising edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output uart_pkg::apb_rsp_s r);
        int n = 0;
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        r = rsp;
        req <= '0;
        `CHK("pready", 1'b1, r.pready)
        @(posedge clk);
    endtask : apb

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        uart_pkg::apb_rsp_s r;
        apb(1'b1, a, d, r);
    endtask : wreg

    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e, input string nm);
        uart_pkg::apb_rsp_s r;
        apb(1'b0, a, 32'h0, r);
        `CHK(nm, e, r.prdata & m)
    endtask : rchk

    // sends one data byte and captures the frame on the line
    task automatic tx_frame(input logic [7:0] d, input logic ninth,
        input int nb, input int per, input logic [7:0] c);
        logic [10:0] e;
        e = (nb == 8) ? {3'b000, d} : (nb == 10) ? {2'b01, d, 1'b0}
            : {1'b1, ninth, d, 1'b0};
        fork
            uart_remote_node_inst.grab(nb, per, got);
            begin
                wreg(uart_pkg::OFF_DATA, {24'h0, d});
                repeat (4 * per) @(posedge clk);
                rchk(uart_pkg::OFF_CTRL, 32'h2, 32'h0, "tx flag early");
            end
        join
        `CHK("tx frame", e, got)
        rchk(uart_pkg::OFF_CTRL, 32'h2, 32'h2, "tx flag");
        wreg(uart_pkg::OFF_CTRL, {24'h0, c});
    endtask : tx_frame

    // a frame is taken only if its byte shows up in the data register
    task automatic rx_frame(input logic [7:0] d, input logic ninth,
        input logic stp, input int nb, input int per, input logic ri,
        input logic [7:0] ed);
        logic [31:0] m;
        m = (d == ed) ? 32'h5 : 32'h1;
        uart_remote_node_inst.send(nb, (nb == 10) ? {1'b0, stp, d, 1'b0}
            : {stp, ninth, d, 1'b0}, per);
        repeat (4) @(posedge clk);
        rchk(uart_pkg::OFF_DATA, 32'hFF, {24'h0, ed}, "rx data");
        rchk(uart_pkg::OFF_CTRL, m, {29'h0, ninth | ((nb == 10) & stp), 1'b0,
            ri} & m, "rx flags");
    endtask : rx_frame

    task automatic t_reset();
        uart_pkg::apb_rsp_s r;
        for (int i = 0; i <= 24; i += 4) begin
            rchk(8'(i), 32'hFFFF_FFFF, 32'h0, "reset value");
        end
        apb(1'b0, uart_pkg::OFF_T1RLD + 8'h04, 32'h0, r);
        `CHK("unmapped error", 1'b1, r.pslverr)
        `CHK("unmapped data", 32'h0, r.prdata)
        `CHK("idle line", 1'b1, tx_line)
    endtask : t_reset

    // shift mode: data bits on the transmit line at core/12, then a receive
    task automatic t_mode0();
        tx_frame(8'h5A, 1'b0, 8, 12, 8'h00);
        wreg(uart_pkg::OFF_CTRL, 32'h10);
        repeat (120) @(posedge clk);
        rchk(uart_pkg::OFF_CTRL, 32'h1, 32'h1, "shift rx flag");
        rchk(uart_pkg::OFF_DATA, 32'hFF, 32'hFF, "shift rx data");
    endtask : t_mode0

    // timer one autoreload, doubled, reload 0xFE: 32 cycles a bit
    task automatic t_mode1();
        wreg(uart_pkg::OFF_TMODE, 32'h20);
        wreg(uart_pkg::OFF_T1RLD, 32'hFE);
        wreg(uart_pkg::OFF_PWR, 32'h80);
        wreg(uart_pkg::OFF_CTRL, 32'h50);
        tx_frame(8'hA5, 1'b0, 10, 32, 8'h50);
        rx_frame(8'h3C, 1'b0, 1'b1, 10, 32, 1'b1, 8'h3C);
        rx_frame(8'h55, 1'b0, 1'b1, 10, 32, 1'b1, 8'h3C);
        wreg(uart_pkg::OFF_CTRL, 32'h50);
        rx_frame(8'h66, 1'b0, 1'b0, 10, 32, 1'b0, 8'h3C);
    endtask : t_mode1

    task automatic t_mode2();
        wreg(uart_pkg::OFF_PWR, 32'h00);
        wreg(uart_pkg::OFF_CTRL, 32'h98);
        tx_frame(8'h5A, 1'b1, 11, 32, 8'h98);
        wreg(uart_pkg::OFF_PWR, 32'h80);
        wreg(uart_pkg::OFF_CTRL, 32'h90);
        tx_frame(8'h0F, 1'b0, 11, 16, 8'h90);
        wreg(uart_pkg::OFF_CTRL, 32'hB0);
        rx_frame(8'h11, 1'b0, 1'b1, 11, 16, 1'b0, 8'h3C);
        rx_frame(8'hC3, 1'b1, 1'b1, 11, 16, 1'b1, 8'hC3);
        wreg(uart_pkg::OFF_CTRL, 32'h90);
    endtask : t_mode2

    // transmit on timer two (64 cycles), receive on timer one (32)
    task automatic t_mode3();
        wreg(uart_pkg::OFF_CTRL, 32'hD0);
        wreg(uart_pkg::OFF_T2RLD, 32'hFFFE);
        wreg(uart_pkg::OFF_T2CTRL, 32'h10);
        tx_frame(8'h81, 1'b0, 11, 64, 8'hD0);
        rx_frame(8'h7E, 1'b1, 1'b1, 11, 32, 1'b1, 8'h7E);
        ext <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(uart_pkg::OFF_T2CTRL, 32'hC0, 32'h40, "timer two flags");
        wreg(uart_pkg::OFF_CTRL, 32'hD0);
    endtask : t_mode3

    task automatic t_noise();
        wreg(uart_pkg::OFF_CTRL, 32'h50);
        uart_remote_node_inst.send(1, 11'h000, 6);
        repeat (400) @(posedge clk);
        rchk(uart_pkg::OFF_CTRL, 32'h1, 32'h0, "short start");
        wreg(uart_pkg::OFF_CTRL, 32'h40);
        rx_frame(8'h99, 1'b0, 1'b1, 10, 32, 1'b0, 8'h7E);
    endtask : t_noise

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_mode0();
        t_mode1();
        t_mode2();
        t_mode3();
        t_noise();
        wrap_up();
    end

    // the whole run needs well under 20000 cycles
    initial begin
        #500000;
        error_cnt++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule : uart_async_modes_baud_select_tb_top
